/* File: pkg/asbl_pkg.sv */
/*
  constants and carrier types for the host-side controller of an asynchronous
  512k x 16 static memory with two byte lanes.
  assumes a single 10 MHz clock and a synchronous active-high reset.
*/
// Notes on behaviour
// - begin write with select and strobe low
// - end write by raising; data held stable
// - strobe-ended write: float plus setup time
// - wait 100 us after power-up
package asbl_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  // ---------------------------------------------------------------
  // timing, fastest grade, ns unless noted
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 100;
  localparam int POWERUP_WAIT_TIME_US = 100;
  localparam int READ_CYCLE_NS      = 10;
  localparam int WRITE_PULSE_NS     = 7;
  localparam int WRITE_FLOAT_DELAY_NS = 5;
  localparam int WRITE_DATA_SETUP_NS  = 5;

  // least times round up, never under one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int POWERUP_CYC = cyc_up(POWERUP_WAIT_TIME_US * 1000);
  localparam int READ_CYC    = cyc_up(READ_CYCLE_NS);
  localparam int WRITE_CYC   = cyc_up(WRITE_PULSE_NS);
  localparam int WR_HOLD_CYC = cyc_up(WRITE_FLOAT_DELAY_NS + WRITE_DATA_SETUP_NS);
  localparam int CNT_W       = 16;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              write;
    logic [1:0]        lane;   // bit0 low lane, bit1 high lane
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asbl_req_t;

  typedef struct packed {
    logic              chip_sel_n;
    logic              out_drv_n;
    logic              wr_strobe_n;
    logic              low_lane_en_n;
    logic              high_lane_en_n;
    logic [ADDR_W-1:0] addr;
  } asbl_pins_t;

  typedef enum logic [2:0] {
    ST_POWERUP, ST_IDLE, ST_READ, ST_WSETUP, ST_WRITE, ST_WEND
  } asbl_state_t;

endpackage

/* File: logic/asbl_timer.sv */
/*
  down counter used to hold the read and write-strobe phases of the memory cycle.
  assumes load and count are not asserted together with reset released late.
*/
`timescale 1ns/1ps
module asbl_timer #(
  parameter int W = 16
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);
  import asbl_pkg::*;

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = value;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done = (count == '0) && !load;

endmodule // asbl_timer

/* File: logic/asbl_ctrl.sv */
/*
  host controller: takes one read or write request at a time and runs the
  strobes of an asynchronous 512k x 16 memory from a single clock.
  assumes the memory powers up together with this logic and that the data
  pins are resolved from dq_out and dq_oe outside.
*/
`timescale 1ns/1ps
module asbl_ctrl #(
  parameter int POWERUP_CYCLES = asbl_pkg::POWERUP_CYC
) (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      req_valid,
  output logic                           req_ready,
  input  wire asbl_pkg::asbl_req_t       req,
  output logic                           rsp_valid,
  output logic [asbl_pkg::DATA_W-1:0]    rsp_data,
  output asbl_pkg::asbl_pins_t           pins,
  input  wire logic [asbl_pkg::DATA_W-1:0] dq_in,
  output logic [asbl_pkg::DATA_W-1:0]    dq_out,
  output logic [asbl_pkg::DATA_W-1:0]    dq_oe
);
  import asbl_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    asbl_state_t       st;
    asbl_pins_t        pins;
    logic [DATA_W-1:0] dq_out;
    logic [DATA_W-1:0] dq_oe;
    logic [1:0]        lane;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic [CNT_W-1:0]  pu_cnt;
  } asbl_ctrl_t;

  asbl_ctrl_t s;
  asbl_ctrl_t next_s;

  logic             t_load;
  logic [CNT_W-1:0] t_value;
  logic             t_done;

  asbl_timer #(.W(CNT_W)) u_timer (
    .clock (clock),
    .rst   (rst),
    .load  (t_load),
    .value (t_value),
    .done  (t_done)
  );

  localparam asbl_pins_t IDLE_PINS = '{chip_sel_n: 1'b1, out_drv_n: 1'b1,
    wr_strobe_n: 1'b1, low_lane_en_n: 1'b1, high_lane_en_n: 1'b1, addr: '0};

  assign req_ready = (s.st == ST_IDLE);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s           = s;
    next_s.rsp_valid = 1'b0;
    t_load           = 1'b0;
    t_value          = '0;
    unique case (s.st)
      ST_POWERUP: begin
        // the shared timer clears to zero in reset, so the wait keeps its own count
        if (s.pu_cnt == CNT_W'(POWERUP_CYCLES)) begin
          next_s.st = ST_IDLE;
        end else begin
          next_s.pu_cnt = s.pu_cnt + 1'b1;
        end
      end
      ST_IDLE: begin
        if (req_valid && req.lane != 2'b00) begin
          next_s.pins.addr           = req.addr;
          next_s.pins.low_lane_en_n  = !req.lane[0];
          next_s.pins.high_lane_en_n = !req.lane[1];
          next_s.lane                = req.lane;
          next_s.pins.chip_sel_n     = 1'b0;
          t_load                     = 1'b1;
          if (req.write) begin
            // output drive stays high so the memory never fights us
            next_s.pins.out_drv_n = 1'b1;
            next_s.dq_out         = req.wdata;
            next_s.st             = ST_WSETUP;
            t_value               = CNT_W'(0);
          end else begin
            next_s.pins.out_drv_n = 1'b0;
            next_s.st             = ST_READ;
            t_value               = CNT_W'(READ_CYC);
          end
        end
      end
      ST_READ: begin
        if (t_done) begin
          next_s.rsp_data  = dq_in;
          next_s.rsp_valid = 1'b1;
          next_s.pins      = IDLE_PINS;
          next_s.st        = ST_IDLE;
        end
      end
      ST_WSETUP: begin
        // address and select settle one cycle before the strobe falls
        next_s.dq_oe            = {{8{s.lane[1]}}, {8{s.lane[0]}}};
        next_s.pins.wr_strobe_n = 1'b0;
        t_load                  = 1'b1;
        t_value                 = CNT_W'(WRITE_CYC > WR_HOLD_CYC ? WRITE_CYC : WR_HOLD_CYC);
        next_s.st               = ST_WRITE;
      end
      ST_WRITE: begin
        if (t_done) begin
          // raise the strobe alone; data keeps its value past the edge
          next_s.pins.wr_strobe_n = 1'b1;
          next_s.st               = ST_WEND;
        end
      end
      ST_WEND: begin
        next_s.dq_oe = '0;
        next_s.pins  = IDLE_PINS;
        next_s.st    = ST_IDLE;
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s           <= '0;
      s.st        <= ST_POWERUP;
      s.pins      <= IDLE_PINS;
    end else begin
      s <= next_s;
    end
  end

  assign pins      = s.pins;
  assign dq_out    = s.dq_out;
  assign dq_oe     = s.dq_oe;
  assign rsp_valid = s.rsp_valid;
  assign rsp_data  = s.rsp_data;

  // ---------------------------------------------------------------
  // checks: power-up
  // ---------------------------------------------------------------
  no_early_access_a: assert property (@(posedge clock) disable iff (rst)
    (s.pu_cnt != CNT_W'(POWERUP_CYCLES)) |-> pins.chip_sel_n)
    else $error("access before power-up wait");
  powerup_exit_a: assert property (@(posedge clock) disable iff (rst)
    (s.st == ST_POWERUP && s.pu_cnt == CNT_W'(POWERUP_CYCLES)) |=> req_ready)
    else $error("idle not reached after power-up wait");

  // ---------------------------------------------------------------
  // checks: write
  // ---------------------------------------------------------------
  write_needs_both_a: assert property (@(posedge clock) disable iff (rst)
    !pins.wr_strobe_n |-> !pins.chip_sel_n && pins.out_drv_n)
    else $error("strobe low without select or with drive");
  data_drive_write_a: assert property (@(posedge clock) disable iff (rst)
    (dq_oe != '0) |-> !pins.chip_sel_n && pins.out_drv_n)
    else $error("data driven outside write");
  data_setup_a: assert property (@(posedge clock) disable iff (rst)
    $fell(pins.wr_strobe_n) |-> $stable(dq_out))
    else $error("write data moved as strobe fell");
  data_stable_end_a: assert property (@(posedge clock) disable iff (rst)
    $rose(pins.wr_strobe_n) |-> $stable(dq_out) && (dq_oe != '0))
    else $error("data moved at write end");
  // at one cycle per phase the strobe must stay low over two sampling edges
  pulse_length_a: assert property (@(posedge clock) disable iff (rst)
    $fell(pins.wr_strobe_n) |-> !pins.wr_strobe_n [*2])
    else $error("write pulse too short");
  strobe_ends_write_a: assert property (@(posedge clock) disable iff (rst)
    $rose(pins.wr_strobe_n) |-> !pins.chip_sel_n && pins.out_drv_n)
    else $error("write not ended by the strobe");
  select_after_end_a: assert property (@(posedge clock) disable iff (rst)
    $rose(pins.wr_strobe_n) |=> pins.chip_sel_n && (dq_oe == '0))
    else $error("select or data left after write");
  lane_high_wr_a: assert property (@(posedge clock) disable iff (rst)
    (s.st == ST_WRITE && s.lane == 2'b10) |-> dq_oe == 16'hff00)
    else $error("high lane write drive wrong");
  lane_low_wr_a: assert property (@(posedge clock) disable iff (rst)
    (s.st == ST_WRITE && s.lane == 2'b01) |-> dq_oe == 16'h00ff)
    else $error("low lane write drive wrong");

  // ---------------------------------------------------------------
  // checks: read and hold
  // ---------------------------------------------------------------
  lane_low_read_a: assert property (@(posedge clock) disable iff (rst)
    (s.st == ST_READ && s.lane == 2'b01) |-> !pins.low_lane_en_n && pins.high_lane_en_n)
    else $error("low lane read enables wrong");
  lane_high_read_a: assert property (@(posedge clock) disable iff (rst)
    (s.st == ST_READ && s.lane == 2'b10) |-> pins.low_lane_en_n && !pins.high_lane_en_n)
    else $error("high lane read enables wrong");
  read_no_drive_a: assert property (@(posedge clock) disable iff (rst)
    !pins.out_drv_n |-> pins.wr_strobe_n && (dq_oe == '0))
    else $error("data driven while memory output on");
  addr_held_a: assert property (@(posedge clock) disable iff (rst)
    (!pins.chip_sel_n && !$past(pins.chip_sel_n)) |-> $stable(pins.addr))
    else $error("address moved inside an access");
  lanes_held_a: assert property (@(posedge clock) disable iff (rst)
    (!pins.chip_sel_n && !$past(pins.chip_sel_n)) |->
      $stable(pins.low_lane_en_n) && $stable(pins.high_lane_en_n))
    else $error("lane enables moved inside an access");
  read_answer_a: assert property (@(posedge clock) disable iff (rst)
    (req_valid && req_ready && !req.write && req.lane != 2'b00) |-> ##[2:3] rsp_valid)
    else $error("read answer late");

  // ---------------------------------------------------------------
  // cover
  // ---------------------------------------------------------------
  read_cov_c: cover property (@(posedge clock) rsp_valid);
  write_cov_c: cover property (@(posedge clock) $rose(pins.wr_strobe_n));
  low_wr_cov_c: cover property (@(posedge clock) s.st == ST_WRITE && s.lane == 2'b01);
  read_start_cov_c: cover property (@(posedge clock)
    $fell(pins.chip_sel_n) && !pins.out_drv_n);
  powerup_cov_c: cover property (@(posedge clock) s.st == ST_POWERUP ##1 s.st == ST_IDLE);

endmodule // asbl_ctrl

/* File: testbench/asbl_mem_model.sv */
/*
  behavioural model of the two-lane asynchronous static memory.
  assumes the controller's pin struct and split data pins; clock only ages floats.
*/
`timescale 1ns/1ps
module asbl_mem_model
  import asbl_pkg::*;
(
  input  wire logic                    clock,
  input  wire asbl_pkg::asbl_pins_t    pins,
  input  wire logic [asbl_pkg::DATA_W-1:0] dq_out,
  input  wire logic [asbl_pkg::DATA_W-1:0] dq_oe,
  output logic [asbl_pkg::DATA_W-1:0]  dq_in
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] float_pat = 16'h5a5a;
  logic [DATA_W-1:0] drv_en;
  logic              sel, wr, rd;
  // floating lines must not look like held data
  always @(posedge clock) float_pat <= ~float_pat;
  always @* begin
    sel = !pins.chip_sel_n;
    wr = sel && !pins.wr_strobe_n;
    rd = sel && !pins.out_drv_n && pins.wr_strobe_n;
    drv_en = {{8{rd && !pins.high_lane_en_n}}, {8{rd && !pins.low_lane_en_n}}};
    dq_in = (dq_oe & dq_out) | (~dq_oe & drv_en & mem[pins.addr])
          | (~dq_oe & ~drv_en & float_pat);
  end
  always @* begin
    if (wr && !pins.low_lane_en_n) mem[pins.addr][7:0] = dq_in[7:0];
    if (wr && !pins.high_lane_en_n) mem[pins.addr][15:8] = dq_in[15:8];
  end
endmodule // asbl_mem_model

/* File: testbench/async_sram_byte_lane_port_tb.sv */
/*
  self-checking bench for the memory controller with a memory model.
  assumes the power-up wait shortened to 4 cycles.
*/
`timescale 1ns/1ps
module async_sram_byte_lane_port_tb;
  import asbl_pkg::*;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic              req_valid = 1'b0;
  asbl_req_t         req = '0;
  logic              req_ready, rsp_valid;
  logic [DATA_W-1:0] rsp_data, dq_in, dq_out, dq_oe;
  asbl_pins_t        pins;
  logic [DATA_W-1:0] ref_mem [0:7];
  int                bad_count = 0;
  int                checks_done = 0;
  initial forever #50 clock = ~clock;
  asbl_ctrl #(.POWERUP_CYCLES(4)) dut_u (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  asbl_mem_model mem_u (.clock(clock), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in));
  function automatic logic [15:0] lane_mask(input logic [1:0] lane);
    return {{8{lane[1]}}, {8{lane[0]}}};
  endfunction
  // only the two ends of the address range are used: top bit and low two bits pick a slot
  function automatic logic [2:0] slot(input logic [18:0] a);
    return {a[18], a[1:0]};
  endfunction
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp,
                            input logic [15:0] mask);
    checks_done++;
    if ((got & mask) !== (exp & mask)) begin
      bad_count++;
      $display("unexpected at %0t: data %h want %h mask %h", $time, got, exp, mask);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  // one request, held from a falling edge until the edge that takes it
  task automatic access(input logic wr, input logic [1:0] lane, input logic [18:0] a,
                        input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clock);
    req_valid = 1'b1;
    req = '{write: wr, lane: lane, addr: a, wdata: d};
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    check_bit(req_ready, 1'b1);
    @(posedge clock);
    @(negedge clock);
    req_valid = 1'b0;
    if (wr) begin
      ref_mem[slot(a)] = (ref_mem[slot(a)] & ~lane_mask(lane)) | (d & lane_mask(lane));
    end else begin
      @(negedge clock);
      @(negedge clock);
      check_bit(rsp_valid, 1'b1);
      check_word(rsp_data, ref_mem[slot(a)], lane_mask(lane));
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    logic [18:0] a;
    logic [1:0]  lane;
    void'($urandom(61));
    repeat (4) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check_bit(req_ready, 1'b0);
    $display("test power-up done");
    for (int i = 0; i < 8; i++) begin
      a = (i < 4) ? 19'(i) : 19'h7fff8 + 19'(i);
      access(1'b1, 2'b11, a, 16'($urandom));
      access(1'b0, 2'b11, a, 16'h0000);
    end
    $display("test full words done");
    for (int l = 1; l < 4; l++) begin
      access(1'b1, 2'(l), 19'h7ffff, 16'($urandom));
      for (int r = 1; r < 4; r++) access(1'b0, 2'(r), 19'h7ffff, 16'h0000);
    end
    $display("test lane corners done");
    @(negedge clock);
    req_valid = 1'b1;
    req = '{write: 1'b1, lane: 2'b00, addr: 19'h00000, wdata: 16'hffff};
    @(negedge clock);
    req_valid = 1'b0;
    repeat (3) @(negedge clock);
    check_bit(rsp_valid, 1'b0);
    access(1'b0, 2'b11, 19'h00000, 16'h0000);
    $display("test empty lane done");
    for (int i = 0; i < 60; i++) begin
      a = ($urandom_range(0, 1) == 1) ? 19'h7ffff - 19'($urandom_range(0, 3))
                                       : 19'($urandom_range(0, 3));
      lane = 2'($urandom_range(1, 3));
      access(1'($urandom_range(0, 1)), lane, a, 16'($urandom));
    end
    $display("test random done");
    summarize();
  end
endmodule // async_sram_byte_lane_port_tb
